//--- src/srg_regs.svh
// Register map, field positions and reset values of the status register groups
`ifndef SRG_REGS_SVH
`define SRG_REGS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define SRG_NUM_CH 4
`define SRG_W 16
`define SRG_APB_AW 12
`define SRG_APB_DW 32
`define SRG_CH_IDX_W 3

// ****************************************************************
// Address pages: global page and per-channel page
// ****************************************************************
`define SRG_PAGE_GLB 4'h0
`define SRG_PAGE_CH 4'h1
`define SRG_GLB_SLOT 3'h0

// ****************************************************************
// Global page offsets (frame group, commands, summary)
// ****************************************************************
`define SRG_OFF_FRM_COND 5'h00
`define SRG_OFF_FRM_EVT 5'h04
`define SRG_OFF_FRM_EN 5'h08
`define SRG_OFF_FRM_FALL 5'h0C
`define SRG_OFF_FRM_RISE 5'h10
`define SRG_OFF_CMD 5'h14
`define SRG_OFF_SUMMARY 5'h18

// ****************************************************************
// Channel page offsets (operation group and protection condition)
// ****************************************************************
`define SRG_OFF_OP_COND 5'h00
`define SRG_OFF_OP_EVT 5'h04
`define SRG_OFF_OP_EN 5'h08
`define SRG_OFF_OP_FALL 5'h0C
`define SRG_OFF_OP_RISE 5'h10
`define SRG_OFF_EDP_COND 5'h14

// ****************************************************************
// Command and summary bit positions
// ****************************************************************
`define SRG_CMD_INST_RESET 0
`define SRG_CMD_PRESET 1
`define SRG_CMD_CLEAR_STATUS 2
`define SRG_SUM_FRAME 0
`define SRG_SUM_OPERATION_SUMMARY_BIT 1

// ****************************************************************
// Reset and preset values
// ****************************************************************
`define SRG_EN_PRESET 16'h0000
`define SRG_FALL_PRESET 16'h0000
`define SRG_RISE_PRESET 16'hFFFF
`define SRG_WORD_ZERO 16'h0000
`define SRG_DATA_ZERO 32'h0000_0000

`endif

//--- src/srg_pkg.sv
// Types shared by the status register groups
`default_nettype none
`include "srg_regs.svh"

package srg_pkg;

	// ****************************************************************
	// Register word and one status group
	// ****************************************************************
	typedef logic [`SRG_W-1:0] srg_word_t;

	typedef struct packed {
		srg_word_t cond;
		srg_word_t evt;
		srg_word_t en;
		srg_word_t fall;
		srg_word_t rise;
	} srg_group_t;

	// ****************************************************************
	// APB request as seen by the slave
	// ****************************************************************
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`SRG_APB_AW-1:0] paddr;
		logic [`SRG_APB_DW-1:0] pwdata;
	} srg_apb_req_t;

	// ****************************************************************
	// Whole state of the register bank
	// ****************************************************************
	typedef struct packed {
		srg_word_t frm_s1;
		srg_word_t frm_s2;
		srg_group_t frm;
		logic [`SRG_NUM_CH-1:0][`SRG_W-1:0] op_s1;
		logic [`SRG_NUM_CH-1:0][`SRG_W-1:0] op_s2;
		srg_group_t [`SRG_NUM_CH-1:0] operation_summary_bit;
		logic [`SRG_NUM_CH-1:0][`SRG_W-1:0] edp_s1;
		logic [`SRG_NUM_CH-1:0][`SRG_W-1:0] edp_s2;
		logic [`SRG_NUM_CH-1:0][`SRG_W-1:0] edp_cond;
		logic [`SRG_APB_DW-1:0] rdata;
		logic err;
		logic [1:0] summary;
	} srg_state_t;

endpackage : srg_pkg
`default_nettype wire

//--- src/srg_status_groups.sv
// Status register groups: frame, per-channel operation and protection condition
//
// Summary of operation
// - Frame and operation groups have condition, enable, event, falling and rising filter registers.
// - Condition register mirrors live inputs; reading it changes nothing.
// - Condition bit clears by itself when its condition goes away.
// - Instrument reset clears condition bits except conditions still present.
// - Per-channel read-only protection condition register, not cleared by reading.
// - Event register is read-only, latches filtered transitions, holds until cleared.
// - Reading frame or operation event register returns it, then clears it.
// - Instrument reset leaves event registers unchanged.
// - Enable register masks which frame event bits drive the frame summary.
// - Status preset clears every enable register bit.
// - Clear-status clears event registers, leaves enable registers unchanged.
// - Falling filter bit set: a 1-to-0 condition change sets the event bit.
// - Rising filter bit set: a 0-to-1 condition change sets the event bit.
// - Both filter bits set: any condition change sets the event bit.
// - Both filter bits clear: no condition change sets the event bit.
// - Status preset sets all rising filter bits, clears all falling filter bits.
// - A query returns the binary-weighted sum of the set bits.
// - Operation group keeps separate condition and event registers per channel.
// - Operation summary is driven only by enabled operation event bits.
`timescale 1ns/1ps
`default_nettype none
`include "srg_regs.svh"

module srg_status_groups
	import srg_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire srg_apb_req_t apb_req_i,
	output logic [`SRG_APB_DW-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Live condition inputs from the instrument
	input wire logic [`SRG_W-1:0] frame_cond_i,
	input wire logic [`SRG_NUM_CH-1:0][`SRG_W-1:0] operation_summary_bit_cond_i,
	input wire logic [`SRG_NUM_CH-1:0][`SRG_W-1:0] excessive_dynamic_protection_i,
	// Summary bits towards the status byte
	output logic frame_summary_o,
	output logic operation_summary_bit_o
);

	// ****************************************************************
	// State
	// ****************************************************************
	srg_state_t s;
	srg_state_t next_s;

	// Decode results shared with the assertions
	logic setup;
	logic access;
	logic wr_acc;
	logic rd_acc;
	logic glb_hit;
	logic ch_hit;
	logic [`SRG_CH_IDX_W-1:0] ch_sel;
	logic [4:0] off;
	logic cmd_wr;
	logic inst_reset;
	logic preset;
	logic clear_status;
	srg_word_t frm_set;

	// ****************************************************************
	// One group step: mirror, edge filter, latch, read and status clears
	// ****************************************************************
	function automatic srg_group_t srg_step(
		input srg_group_t g,
		input srg_word_t live,
		input logic clr,
		input srg_word_t rd_clr
	);
		srg_group_t r;
		srg_word_t up;
		srg_word_t down;
		srg_word_t set;
		r = g;
		up = live & ~g.cond;
		down = ~live & g.cond;
		// Both filters at one pass any edge, both at zero pass none
		set = (up & g.rise) | (down & g.fall);
		// Condition follows the live level, so it drops with the condition
		r.cond = live;
		// Clear-status clears every bit, a read only the bits it handed out; a set wins over any clear
		if (clr)
		begin
			r.evt = set;
		end
		else
		begin
			r.evt = (g.evt & ~rd_clr) | set;
		end
		return r;
	endfunction : srg_step

	// ****************************************************************
	// APB decode
	// ****************************************************************
	always_comb
	begin
		setup = apb_req_i.psel & ~apb_req_i.penable;
		access = apb_req_i.psel & apb_req_i.penable;
		wr_acc = access & apb_req_i.pwrite;
		rd_acc = access & ~apb_req_i.pwrite;
		off = apb_req_i.paddr[4:0];
		ch_sel = apb_req_i.paddr[7:5];
		glb_hit = (apb_req_i.paddr[11:8] == `SRG_PAGE_GLB) && (ch_sel == `SRG_GLB_SLOT);
		ch_hit = (apb_req_i.paddr[11:8] == `SRG_PAGE_CH)
			&& (ch_sel < `SRG_CH_IDX_W'(`SRG_NUM_CH));
		cmd_wr = wr_acc & glb_hit & (off == `SRG_OFF_CMD);
		inst_reset = cmd_wr & apb_req_i.pwdata[`SRG_CMD_INST_RESET];
		preset = cmd_wr & apb_req_i.pwdata[`SRG_CMD_PRESET];
		clear_status = cmd_wr & apb_req_i.pwdata[`SRG_CMD_CLEAR_STATUS];
		frm_set = ((s.frm_s2 & ~s.frm.cond) & s.frm.rise)
			| ((~s.frm_s2 & s.frm.cond) & s.frm.fall);
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		srg_word_t rd_val;
		logic hit;
		srg_word_t frm_rd_clr;
		srg_word_t op_rd_clr;
		logic op_any;
		rd_val = `SRG_WORD_ZERO;
		hit = 1'b0;
		frm_rd_clr = `SRG_WORD_ZERO;
		op_rd_clr = `SRG_WORD_ZERO;
		op_any = 1'b0;
		next_s = s;

		// Two-stage synchronisers on all live inputs
		next_s.frm_s1 = frame_cond_i;
		next_s.frm_s2 = s.frm_s1;
		next_s.op_s1 = operation_summary_bit_cond_i;
		next_s.op_s2 = s.op_s1;
		next_s.edp_s1 = excessive_dynamic_protection_i;
		next_s.edp_s2 = s.edp_s1;
		// Protection condition only mirrors; nothing latches it
		next_s.edp_cond = s.edp_s2;

		// Read mux, plain binary weighting of the bits
		if (glb_hit)
		begin
			unique case (off)
				`SRG_OFF_FRM_COND: begin rd_val = s.frm.cond; hit = 1'b1; end
				`SRG_OFF_FRM_EVT: begin rd_val = s.frm.evt; hit = 1'b1; end
				`SRG_OFF_FRM_EN: begin rd_val = s.frm.en; hit = 1'b1; end
				`SRG_OFF_FRM_FALL: begin rd_val = s.frm.fall; hit = 1'b1; end
				`SRG_OFF_FRM_RISE: begin rd_val = s.frm.rise; hit = 1'b1; end
				`SRG_OFF_CMD: begin rd_val = `SRG_WORD_ZERO; hit = 1'b1; end
				`SRG_OFF_SUMMARY: begin rd_val = `SRG_W'(s.summary); hit = 1'b1; end
				default: begin rd_val = `SRG_WORD_ZERO; hit = 1'b0; end
			endcase
		end
		else if (ch_hit)
		begin
			unique case (off)
				`SRG_OFF_OP_COND: begin rd_val = s.operation_summary_bit[ch_sel].cond; hit = 1'b1; end
				`SRG_OFF_OP_EVT: begin rd_val = s.operation_summary_bit[ch_sel].evt; hit = 1'b1; end
				`SRG_OFF_OP_EN: begin rd_val = s.operation_summary_bit[ch_sel].en; hit = 1'b1; end
				`SRG_OFF_OP_FALL: begin rd_val = s.operation_summary_bit[ch_sel].fall; hit = 1'b1; end
				`SRG_OFF_OP_RISE: begin rd_val = s.operation_summary_bit[ch_sel].rise; hit = 1'b1; end
				`SRG_OFF_EDP_COND: begin rd_val = s.edp_cond[ch_sel]; hit = 1'b1; end
				default: begin rd_val = `SRG_WORD_ZERO; hit = 1'b0; end
			endcase
		end

		// Read data captured in setup so prdata comes from a flop
		if (setup)
		begin
			next_s.rdata = {{(`SRG_APB_DW-`SRG_W){1'b0}}, rd_val};
			next_s.err = ~hit;
		end

		// Read-to-clear of the event registers at the access edge
		if (rd_acc && glb_hit && (off == `SRG_OFF_FRM_EVT))
		begin
			frm_rd_clr = s.rdata[`SRG_W-1:0];
		end
		if (rd_acc && ch_hit && (off == `SRG_OFF_OP_EVT))
		begin
			op_rd_clr = s.rdata[`SRG_W-1:0];
		end

		// Instrument reset touches neither events nor filters; condition reloads live
		next_s.frm = srg_step(s.frm, s.frm_s2, clear_status, frm_rd_clr);
		for (int c = 0; c < `SRG_NUM_CH; c++)
		begin
			next_s.operation_summary_bit[c] = srg_step(s.operation_summary_bit[c], s.op_s2[c], clear_status,
				(ch_sel == `SRG_CH_IDX_W'(c)) ? op_rd_clr : `SRG_WORD_ZERO);
		end

		// Software writes; condition and event registers ignore them
		if (wr_acc && glb_hit)
		begin
			unique case (off)
				`SRG_OFF_FRM_EN: next_s.frm.en = apb_req_i.pwdata[`SRG_W-1:0];
				`SRG_OFF_FRM_FALL: next_s.frm.fall = apb_req_i.pwdata[`SRG_W-1:0];
				`SRG_OFF_FRM_RISE: next_s.frm.rise = apb_req_i.pwdata[`SRG_W-1:0];
				default: ;
			endcase
		end
		else if (wr_acc && ch_hit)
		begin
			unique case (off)
				`SRG_OFF_OP_EN: next_s.operation_summary_bit[ch_sel].en = apb_req_i.pwdata[`SRG_W-1:0];
				`SRG_OFF_OP_FALL: next_s.operation_summary_bit[ch_sel].fall = apb_req_i.pwdata[`SRG_W-1:0];
				`SRG_OFF_OP_RISE: next_s.operation_summary_bit[ch_sel].rise = apb_req_i.pwdata[`SRG_W-1:0];
				default: ;
			endcase
		end

		// Status preset: masks closed, rising edges only
		if (preset)
		begin
			next_s.frm.en = `SRG_EN_PRESET;
			next_s.frm.rise = `SRG_RISE_PRESET;
			next_s.frm.fall = `SRG_FALL_PRESET;
			for (int c = 0; c < `SRG_NUM_CH; c++)
			begin
				next_s.operation_summary_bit[c].en = `SRG_EN_PRESET;
				next_s.operation_summary_bit[c].rise = `SRG_RISE_PRESET;
				next_s.operation_summary_bit[c].fall = `SRG_FALL_PRESET;
			end
		end

		// Summaries from the present registers, so they lag a change by one cycle
		for (int c = 0; c < `SRG_NUM_CH; c++)
		begin
			op_any = op_any | (|(s.operation_summary_bit[c].evt & s.operation_summary_bit[c].en));
		end
		next_s.summary[`SRG_SUM_FRAME] = |(s.frm.evt & s.frm.en);
		next_s.summary[`SRG_SUM_OPERATION_SUMMARY_BIT] = op_any;
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s <= '0;
			s.frm.rise <= `SRG_RISE_PRESET;
			for (int c = 0; c < `SRG_NUM_CH; c++)
			begin
				s.operation_summary_bit[c].rise <= `SRG_RISE_PRESET;
			end
		end
		else
		begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Zero-wait slave; error only for unmapped addresses
	assign pready_o = 1'b1;
	assign pslverr_o = s.err & access;
	assign prdata_o = s.rdata;
	assign frame_summary_o = s.summary[`SRG_SUM_FRAME];
	assign operation_summary_bit_o = s.summary[`SRG_SUM_OPERATION_SUMMARY_BIT];

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	// Named sequences: a frame event read and a clear-status command without preset
	sequence seq_frm_evt_read;
		rd_acc && glb_hit && (off == `SRG_OFF_FRM_EVT);
	endsequence

	sequence seq_clear_status;
		clear_status && !preset;
	endsequence

	// Steady live input reaches the condition register within three edges
	a_cond_mirror: assert property ($stable(frame_cond_i) [*4]
		|-> s.frm.cond == frame_cond_i)
		else $error("frame condition does not follow live input");

	// Rising edge with rising filter latches
	a_rise_latch: assert property (((s.frm_s2 & ~s.frm.cond & s.frm.rise) != '0)
		|=> ((s.frm.evt & $past(s.frm_s2 & ~s.frm.cond & s.frm.rise))
			== $past(s.frm_s2 & ~s.frm.cond & s.frm.rise)))
		else $error("rising transition not latched");

	// Falling edge with falling filter latches
	a_fall_latch: assert property (((~s.frm_s2 & s.frm.cond & s.frm.fall) != '0)
		|=> ((s.frm.evt & $past(~s.frm_s2 & s.frm.cond & s.frm.fall))
			== $past(~s.frm_s2 & s.frm.cond & s.frm.fall)))
		else $error("falling transition not latched");

	// No new event bit where both filters were zero
	a_filter_block: assert property ((s.frm.evt & ~$past(s.frm.evt)
		& ~($past(s.frm.rise) | $past(s.frm.fall))) == '0)
		else $error("event set through closed filters");

	// Any change passes when both filters open
	a_any_edge: assert property (((s.frm_s2 ^ s.frm.cond) & s.frm.rise & s.frm.fall) != '0
		|=> (s.frm.evt & $past((s.frm_s2 ^ s.frm.cond) & s.frm.rise & s.frm.fall)) != '0)
		else $error("two-way filter missed a change");

	// Read clears the returned bits unless freshly set
	a_read_clear: assert property (seq_frm_evt_read
		|=> (s.frm.evt & $past(s.rdata[`SRG_W-1:0]) & ~$past(frm_set)) == '0)
		else $error("event register not cleared by read");

	// Instrument reset keeps latched events
	a_reset_keep: assert property (inst_reset && !clear_status && !preset
		|=> (s.frm.evt & $past(s.frm.evt)) == $past(s.frm.evt))
		else $error("instrument reset disturbed events");

	// Preset values land on the next edge
	a_preset_vals: assert property (preset |=> s.frm.en == `SRG_EN_PRESET
		&& s.frm.rise == `SRG_RISE_PRESET && s.frm.fall == `SRG_FALL_PRESET)
		else $error("preset values wrong");

	// Clear-status empties events and keeps enables
	a_clear_status: assert property (seq_clear_status
		|=> s.frm.en == $past(s.frm.en) && (s.frm.evt & ~$past(frm_set)) == '0)
		else $error("clear-status behaved wrongly");

	// Frame summary one cycle behind enabled events
	a_frm_summary: assert property (frame_summary_o == $past(|(s.frm.evt & s.frm.en)))
		else $error("frame summary wrong");

	// Helper for the operation summary check
	logic op_enabled_any;
	always_comb
	begin
		op_enabled_any = 1'b0;
		for (int c = 0; c < `SRG_NUM_CH; c++)
		begin
			op_enabled_any = op_enabled_any | (|(s.operation_summary_bit[c].evt & s.operation_summary_bit[c].en));
		end
	end

	// Operation summary follows only enabled channel events, one cycle behind
	a_operation_summary_bit_masked: assert property (operation_summary_bit_o == $past(op_enabled_any))
		else $error("operation summary not masked");

	// Protection condition is not cleared by reading
	a_edp_read: assert property (rd_acc && ch_hit && (off == `SRG_OFF_EDP_COND)
		|=> s.edp_cond == $past(s.edp_s2))
		else $error("protection condition altered by read");

endmodule : srg_status_groups
`default_nettype wire

//--- dv/tb.sv
// Self-checking testbench for the status register groups
`timescale 1ns/1ps
`default_nettype none
`include "srg_regs.svh"

module tb
	import srg_pkg::*;
;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic ref_clk_i;
	logic rst_n_i;
	srg_apb_req_t req;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] frame_cond;
	logic [3:0][15:0] operation_summary_bit_cond;
	logic [3:0][15:0] excessive_dynamic_protection;
	logic frame_sum;
	logic operation_summary_bit_sum;
	int err_total;
	int checks;
	int ch;
	logic [15:0] f, rr, nf, no, old_f, old_o;
	logic [15:0] xf, xo;
	logic [31:0] r;
	logic e;
	logic [11:0] bad [3] = '{12'h01C, 12'h180, 12'h200};

	srg_status_groups srg_status_groups_inst (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.apb_req_i(req),
		.prdata_o(prdata),
		.pready_o(pready),
		.pslverr_o(pslverr),
		.frame_cond_i(frame_cond),
		.operation_summary_bit_cond_i(operation_summary_bit_cond),
		.excessive_dynamic_protection_i(excessive_dynamic_protection),
		.frame_summary_o(frame_sum),
		.operation_summary_bit_o(operation_summary_bit_sum)
	);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge ref_clk_i);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge ref_clk_i);
		req.penable <= 1'b1;
		n = 0;
		// Answer looked at mid-cycle, where it is settled for the coming edge
		@(negedge ref_clk_i);
		while (pready !== 1'b1 && n < 20)
		begin
			@(negedge ref_clk_i);
			n++;
		end
		if (n >= 20)
			err_total++;
		rd = prdata;
		er = pslverr;
		// Released only after the edge that completes the transfer
		@(posedge ref_clk_i);
		req <= '0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic y;
		apb(1'b1, a, d, x, y);
	endtask : wr

	// Read a word; upper half must read zero
	task automatic rchk(input string what, input logic [11:0] a, input logic [15:0] exp);
		logic [31:0] x;
		logic y;
		apb(1'b0, a, 32'h0000_0000, x, y);
		chk(what, x, {16'h0000, exp});
		chk("slverr mapped", {31'h0, y}, 32'h0000_0000);
	endtask : rchk

	// Synchroniser, condition, event and summary all settled
	task automatic settle;
		repeat (6) @(posedge ref_clk_i);
	endtask : settle

	function automatic logic [11:0] gaddr(input logic [4:0] off);
		return {7'h00, off};
	endfunction : gaddr

	function automatic logic [11:0] chaddr(input int c, input logic [4:0] off);
		return 12'(32'h100 + c * 32) + {7'h00, off};
	endfunction : chaddr

	function automatic logic [15:0] exp_evt(input logic [15:0] o, n, fl, ri);
		return (~o & n & ri) | (o & ~n & fl);
	endfunction : exp_evt

	task automatic report_and_stop;
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	// ****************************************************************
	// Clock and watchdog
	// ****************************************************************
	initial
	begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	// Far beyond the under one thousand cycles the tests need
	initial
	begin
		#2000000;
		err_total++;
		report_and_stop();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		req = '0;
		frame_cond = '0;
		operation_summary_bit_cond = '0;
		excessive_dynamic_protection = '0;
		rst_n_i = 1'b0;
		err_total = 0;
		checks = 0;
		void'($urandom(32'hDEF3));
		repeat (5) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		// Reset values equal the preset values
		rchk("frame en", gaddr(`SRG_OFF_FRM_EN), 16'h0000);
		rchk("frame fall", gaddr(`SRG_OFF_FRM_FALL), 16'h0000);
		rchk("frame rise", gaddr(`SRG_OFF_FRM_RISE), 16'hFFFF);
		for (int c = 0; c < 4; c++)
		begin
			rchk("op rise", chaddr(c, `SRG_OFF_OP_RISE), 16'hFFFF);
			rchk("op en", chaddr(c, `SRG_OFF_OP_EN), 16'h0000);
		end
		// Holes in the map answer with an error
		foreach (bad[i])
		begin
			apb(1'b0, bad[i], 32'h0000_0000, r, e);
			chk("slverr", {31'h0, e}, 32'h0000_0001);
		end
		// Edge filters, frame and one operation channel; first two are corners
		for (int i = 0; i < 8; i++)
		begin
			f = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
			rr = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
			ch = $urandom % 4;
			nf = 16'($urandom);
			no = 16'($urandom);
			wr(gaddr(`SRG_OFF_FRM_FALL), {16'h0000, f});
			wr(gaddr(`SRG_OFF_FRM_RISE), {16'h0000, rr});
			wr(chaddr(ch, `SRG_OFF_OP_FALL), {16'h0000, f});
			wr(chaddr(ch, `SRG_OFF_OP_RISE), {16'h0000, rr});
			old_f = frame_cond;
			old_o = operation_summary_bit_cond[ch];
			@(posedge ref_clk_i);
			frame_cond <= nf;
			operation_summary_bit_cond[ch] <= no;
			settle();
			rchk("frame cond", gaddr(`SRG_OFF_FRM_COND), nf);
			rchk("frame cond again", gaddr(`SRG_OFF_FRM_COND), nf);
			xf = exp_evt(old_f, nf, f, rr);
			xo = exp_evt(old_o, no, f, rr);
			rchk("frame evt", gaddr(`SRG_OFF_FRM_EVT), xf);
			rchk("frame evt cleared", gaddr(`SRG_OFF_FRM_EVT), 16'h0000);
			rchk("op cond", chaddr(ch, `SRG_OFF_OP_COND), no);
			rchk("op evt", chaddr(ch, `SRG_OFF_OP_EVT), xo);
			rchk("op evt cleared", chaddr(ch, `SRG_OFF_OP_EVT), 16'h0000);
			rchk("other evt", chaddr((ch + 1) % 4, `SRG_OFF_OP_EVT), 16'h0000);
		end
		// Event register cannot be written
		wr(gaddr(`SRG_OFF_FRM_EVT), 32'h0000_FFFF);
		rchk("evt write", gaddr(`SRG_OFF_FRM_EVT), 16'h0000);
		// Protection condition per channel, stable across reads
		@(posedge ref_clk_i);
		for (int c = 0; c < 4; c++)
			excessive_dynamic_protection[c] <= 16'($urandom);
		settle();
		for (int c = 0; c < 4; c++)
		begin
			rchk("edp cond", chaddr(c, `SRG_OFF_EDP_COND), excessive_dynamic_protection[c]);
			rchk("edp again", chaddr(c, `SRG_OFF_EDP_COND), excessive_dynamic_protection[c]);
		end
		// Weighted readback, then preset
		wr(gaddr(`SRG_OFF_FRM_EN), 32'd40);
		rchk("en weight", gaddr(`SRG_OFF_FRM_EN), 16'h0028);
		wr(chaddr(1, `SRG_OFF_OP_FALL), 32'h0000_1234);
		wr(gaddr(`SRG_OFF_CMD), 32'(1 << `SRG_CMD_PRESET));
		rchk("preset en", gaddr(`SRG_OFF_FRM_EN), 16'h0000);
		rchk("preset fall", chaddr(1, `SRG_OFF_OP_FALL), 16'h0000);
		rchk("preset rise", gaddr(`SRG_OFF_FRM_RISE), 16'hFFFF);
		// Frame summary masked by enable
		@(posedge ref_clk_i);
		frame_cond <= 16'h0000;
		settle();
		frame_cond <= 16'h0028;
		settle();
		chk("frame sum off", {31'h0, frame_sum}, 32'h0);
		wr(gaddr(`SRG_OFF_FRM_EN), 32'h0000_0010);
		repeat (2) @(posedge ref_clk_i);
		chk("frame sum disjoint", {31'h0, frame_sum}, 32'h0);
		wr(gaddr(`SRG_OFF_FRM_EN), 32'h0000_0020);
		repeat (2) @(posedge ref_clk_i);
		chk("frame sum on", {31'h0, frame_sum}, 32'h1);
		// Instrument reset keeps events and live conditions
		wr(gaddr(`SRG_OFF_CMD), 32'(1 << `SRG_CMD_INST_RESET));
		settle();
		chk("sum after reset", {31'h0, frame_sum}, 32'h1);
		rchk("cond after reset", gaddr(`SRG_OFF_FRM_COND), 16'h0028);
		// Clear-status clears events but not enable
		wr(gaddr(`SRG_OFF_CMD), 32'(1 << `SRG_CMD_CLEAR_STATUS));
		repeat (2) @(posedge ref_clk_i);
		chk("sum after cls", {31'h0, frame_sum}, 32'h0);
		rchk("en after cls", gaddr(`SRG_OFF_FRM_EN), 16'h0020);
		rchk("evt after cls", gaddr(`SRG_OFF_FRM_EVT), 16'h0000);
		// Reading the event register drops the summary
		frame_cond <= 16'h0000;
		settle();
		frame_cond <= 16'h0020;
		settle();
		rchk("evt read", gaddr(`SRG_OFF_FRM_EVT), 16'h0020);
		repeat (2) @(posedge ref_clk_i);
		chk("sum after read", {31'h0, frame_sum}, 32'h0);
		// Operation summary only from the enabled channel bits
		wr(chaddr(1, `SRG_OFF_OP_EN), 32'h0000_FFFF);
		operation_summary_bit_cond[2] <= 16'h0000;
		settle();
		operation_summary_bit_cond[2] <= 16'h0001;
		settle();
		chk("operation_summary_bit sum off", {31'h0, operation_summary_bit_sum}, 32'h0);
		wr(chaddr(2, `SRG_OFF_OP_EN), 32'h0000_0001);
		repeat (2) @(posedge ref_clk_i);
		chk("operation_summary_bit sum on", {31'h0, operation_summary_bit_sum}, 32'h1);
		rchk("summary reg", gaddr(`SRG_OFF_SUMMARY), 16'(1 << `SRG_SUM_OPERATION_SUMMARY_BIT));
		report_and_stop();
	end

endmodule : tb

`default_nettype wire
